//--- output_status_top.sv
// Output status word and output voltage status byte of a point-of-load
// converter, reached through decoded management-bus command transfers.
// Assumes the bus front end delivers one-cycle read and write strobes with
// the command code, length and data, and that detector inputs are
// synchronous one-cycle or level events from the analog comparators.
//
// Functional notes
// - Status word bit 11 tracks output outside the fault window, unlatched.
// - Not-good low leaves power-ok pin floating; high pulls it low.
// - Host writes never clear the not-good bit.
// - A stack secondary holds the not-good bit at zero.
// - Word bits 10 and 8, voltage status bits 2:0 read zero.
// - Word bit 9 follows an active first-to-alert condition.
// - Word bits 7:0 return the status byte exactly.
// - Voltage flags latch on detection and hold until cleared.
// - Power cycle, clear-faults or output turn-on clear all flags.
// - Writing one to a flag position clears only that flag.
// - Alert masking never touches flag setting or clearing.
// - A disable bit blocks both the flag and the protective response.
// - Bit 7 is the latched overvoltage fault, reset zero.
// - Bit 6 overvoltage warning; also set by fault after soft start.
// - Bit 5 undervoltage warning; also set by an undervoltage fault.
// - Bit 4 latched undervoltage fault, cleared by one or global clears.
// - Bit 3 latches on an out-of-limit voltage request.
// - Voltage status at 7Ah: byte read, byte write to clear.
// - Status word at 79h: word read only, no write form.
// - A write to the status word raises a communication fault.
// - Every status word bit but the zero bits 10 and 8 can raise the alert unless masked.
`timescale 1ns/1ns
`default_nettype none

module output_status_top
	import status_pkg::*;
(
	input  wire logic                        i_core_clk,
	input  wire logic                        i_sys_rst,
	// Decoded command transfers
	input  wire logic                        i_wr_en,
	input  wire logic [7:0]                  i_wr_code,
	input  wire status_pkg::xfer_len_type    i_wr_len,
	input  wire logic [15:0]                 i_wr_data,
	input  wire logic                        i_rd_en,
	input  wire logic [7:0]                  i_rd_code,
	input  wire status_pkg::xfer_len_type    i_rd_len,
	output var  logic                        o_rd_valid,
	output var  logic                        o_rd_hit,
	output var  logic [15:0]                 o_rd_data,
	output var  logic                        o_cml_data_fault,
	// Condition detectors
	input  wire logic                        i_vout_outside_window,
	input  wire logic                        i_ovf_det,
	input  wire logic                        i_ovw_det,
	input  wire logic                        i_uvw_det,
	input  wire logic                        i_uvf_det,
	input  wire logic                        i_limit_req_det,
	input  wire logic                        i_soft_start_done,
	input  wire logic [4:0]                  i_flag_disable,
	input  wire logic                        i_clear_faults,
	input  wire logic                        i_output_turn_on,
	input  wire logic                        i_secondary,
	// Other summaries and the status byte
	input  wire logic                        i_first_to_alert_flag,
	input  wire logic                        i_iout_summary,
	input  wire logic                        i_input_summary,
	input  wire logic                        i_mfr_summary,
	input  wire logic [7:0]                  i_status_byte,
	input  wire logic [15:0]                 i_alert_mask,
	// Responses and pins
	output var  logic [4:0]                  o_fault_response,
	output var  logic                        o_output_not_good_flag,
	output var  logic                        o_power_ok_pin_o,
	output var  logic                        o_power_ok_pin_oe,
	output var  logic                        o_bus_alert_o,
	output var  logic                        o_bus_alert_oe
);

	import status_pkg::*;

	//--------------------------------------------------------------------
	// Command decode helpers
	//--------------------------------------------------------------------

	// Decoding used by both the read and the write path
	function automatic logic is_vout_code(input logic [7:0] code);
		is_vout_code = (code == CMD_VOUT_STATUS);
	endfunction

	function automatic logic is_word_code(input logic [7:0] code);
		is_word_code = (code == CMD_STATUS_WORD);
	endfunction

	//--------------------------------------------------------------------
	// Declarations
	//--------------------------------------------------------------------

	vout_flag_if flag_bus ();

	logic [VOUT_FLAG_COUNT-1:0] detect_raw;
	logic [VOUT_FLAG_COUNT-1:0] detect_ok;
	logic [VOUT_FLAG_COUNT-1:0] set_req;
	logic [VOUT_FLAG_COUNT-1:0] clr_req;
	logic                       clr_all;
	logic                       vout_wr_ok;
	logic                       vout_wr_bad;
	logic                       word_wr;
	logic                       vout_rd_ok;
	logic                       vout_rd_bad;
	logic                       word_rd_ok;
	logic                       word_rd_bad;
	logic                       fault_nxt;
	logic                       not_good;
	logic [7:0]                 vout_status;
	logic [15:0]                status_word;
	logic [15:0]                alert_terms;
	logic                       alert_nxt;
	logic [15:0]                rd_data_nxt;
	logic                       rd_hit_nxt;

	logic                       rd_valid_r;
	logic                       rd_hit_r;
	logic [15:0]                rd_data_r;
	logic                       cml_fault_r;
	logic [4:0]                 response_r;
	logic                       alert_r;

	//--------------------------------------------------------------------
	// Flag set logic
	//--------------------------------------------------------------------

	assign detect_raw[FLAG_OVER_FAULT]  = i_ovf_det;
	assign detect_raw[FLAG_OVER_WARN]   = i_ovw_det;
	assign detect_raw[FLAG_UNDER_WARN]  = i_uvw_det;
	assign detect_raw[FLAG_UNDER_FAULT] = i_uvf_det;
	assign detect_raw[FLAG_LIMIT_REQ]   = i_limit_req_det;

	// Alert masking is deliberately absent here
	assign detect_ok = detect_raw & ~i_flag_disable;

	assign set_req[FLAG_OVER_FAULT]  = detect_ok[FLAG_OVER_FAULT];
	assign set_req[FLAG_UNDER_FAULT] = detect_ok[FLAG_UNDER_FAULT];
	assign set_req[FLAG_LIMIT_REQ]   = detect_ok[FLAG_LIMIT_REQ];

	// A fault caught during soft start is the fixed trip, not a warning
	assign set_req[FLAG_OVER_WARN] = (detect_ok[FLAG_OVER_WARN] |
		(set_req[FLAG_OVER_FAULT] & i_soft_start_done)) &
		~i_flag_disable[FLAG_OVER_WARN];

	assign set_req[FLAG_UNDER_WARN] = (detect_ok[FLAG_UNDER_WARN] |
		set_req[FLAG_UNDER_FAULT]) &
		~i_flag_disable[FLAG_UNDER_WARN];

	//--------------------------------------------------------------------
	// Write decode
	//--------------------------------------------------------------------

	assign vout_wr_ok  = i_wr_en & is_vout_code(i_wr_code) &
		(i_wr_len == LEN_BYTE);
	assign vout_wr_bad = i_wr_en & is_vout_code(i_wr_code) &
		(i_wr_len != LEN_BYTE);
	// The word has no write form; its bits, not-good included, stay put
	assign word_wr     = i_wr_en & is_word_code(i_wr_code);

	// Zeros in the written byte leave their flags alone
	assign clr_req = vout_wr_ok ?
		i_wr_data[VOUT_FLAG_LSB +: VOUT_FLAG_COUNT] :
		VOUT_FLAGS_RESET;

	assign clr_all = i_clear_faults | i_output_turn_on;

	assign flag_bus.set_req = set_req;
	assign flag_bus.clr_req = clr_req;
	assign flag_bus.clr_all = clr_all;

	vout_flag_store u_flags (
		.i_core_clk (i_core_clk),
		.i_sys_rst  (i_sys_rst),
		.flag_bus   (flag_bus)
	);

	//--------------------------------------------------------------------
	// Power-not-good tracking and pin
	//--------------------------------------------------------------------

	power_ok_driver u_power_ok (
		.i_core_clk            (i_core_clk),
		.i_sys_rst             (i_sys_rst),
		.i_vout_outside_window (i_vout_outside_window),
		.i_secondary           (i_secondary),
		.o_not_good            (not_good),
		.o_power_ok_pin_o      (o_power_ok_pin_o),
		.o_power_ok_pin_oe     (o_power_ok_pin_oe)
	);

	//--------------------------------------------------------------------
	// Register views
	//--------------------------------------------------------------------

	assign vout_status = {flag_bus.flags, VOUT_UNSUPPORTED_VAL};

	assign status_word[WORD_VOUT_SUMMARY]  = |flag_bus.flags;
	assign status_word[WORD_IOUT_SUMMARY]  = i_iout_summary;
	assign status_word[WORD_INPUT_SUMMARY] = i_input_summary;
	assign status_word[WORD_MFR_SUMMARY]   = i_mfr_summary;
	assign status_word[WORD_NOT_GOOD]      = not_good;
	assign status_word[WORD_RSVD_HI]       = RSVD_BIT_VAL;
	assign status_word[WORD_OTHER]         = i_first_to_alert_flag;
	assign status_word[WORD_RSVD_LO]       = RSVD_BIT_VAL;
	// No private copy, so the two views can never disagree
	assign status_word[7:0]                = i_status_byte;

	//--------------------------------------------------------------------
	// Read decode
	//--------------------------------------------------------------------

	assign vout_rd_ok  = i_rd_en & is_vout_code(i_rd_code) &
		(i_rd_len == LEN_BYTE);
	assign vout_rd_bad = i_rd_en & is_vout_code(i_rd_code) &
		(i_rd_len != LEN_BYTE);
	assign word_rd_ok  = i_rd_en & is_word_code(i_rd_code) &
		(i_rd_len == LEN_WORD);
	assign word_rd_bad = i_rd_en & is_word_code(i_rd_code) &
		(i_rd_len != LEN_WORD);

	assign rd_hit_nxt  = vout_rd_ok | word_rd_ok;
	assign rd_data_nxt = vout_rd_ok ? {8'h00, vout_status} :
		word_rd_ok ? status_word : WORD_RESET;

	// Wrong protocol at either code counts as invalid data
	assign fault_nxt = word_wr | vout_wr_bad |
		vout_rd_bad | word_rd_bad;

	//--------------------------------------------------------------------
	// Alert and protective response
	//--------------------------------------------------------------------

	// A set mask bit hides its status word bit from the alert only
	assign alert_terms = status_word & ~i_alert_mask;
	assign alert_nxt   = |alert_terms;

	//--------------------------------------------------------------------
	// Registered outputs
	//--------------------------------------------------------------------

	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			rd_valid_r  <= 1'b0;
			rd_hit_r    <= 1'b0;
			rd_data_r   <= WORD_RESET;
			cml_fault_r <= 1'b0;
			response_r  <= VOUT_FLAGS_RESET;
			alert_r     <= 1'b0;
		end else begin
			rd_valid_r  <= i_rd_en;
			rd_hit_r    <= rd_hit_nxt;
			rd_data_r   <= rd_data_nxt;
			cml_fault_r <= fault_nxt;
			response_r  <= detect_ok;
			alert_r     <= alert_nxt;
		end
	end

	assign o_rd_valid             = rd_valid_r;
	assign o_rd_hit               = rd_hit_r;
	assign o_rd_data              = rd_data_r;
	assign o_cml_data_fault       = cml_fault_r;
	assign o_fault_response       = response_r;
	assign o_output_not_good_flag = not_good;
	assign o_bus_alert_o          = PIN_PULL_LEVEL;
	assign o_bus_alert_oe         = alert_r;

endmodule // output_status_top

`default_nettype wire

//--- status_pkg.sv
// Constants shared by the output status word and output voltage flags.
// Assumes a single core clock and byte/word command transfers.
package status_pkg;

	// Command codes
	localparam logic [7:0]  CMD_STATUS_WORD      = 8'h79;
	localparam logic [7:0]  CMD_VOUT_STATUS      = 8'h7a;

	// Output voltage status layout
	localparam int          VOUT_FLAG_COUNT      = 5;
	localparam int          VOUT_FLAG_LSB        = 3;
	localparam int          FLAG_LIMIT_REQ       = 0;
	localparam int          FLAG_UNDER_FAULT     = 1;
	localparam int          FLAG_UNDER_WARN      = 2;
	localparam int          FLAG_OVER_WARN       = 3;
	localparam int          FLAG_OVER_FAULT      = 4;
	localparam logic [4:0]  VOUT_FLAGS_RESET     = 5'h00;
	localparam logic [2:0]  VOUT_UNSUPPORTED_VAL = 3'h0;

	// Status word layout
	localparam int          WORD_VOUT_SUMMARY    = 15;
	localparam int          WORD_IOUT_SUMMARY    = 14;
	localparam int          WORD_INPUT_SUMMARY   = 13;
	localparam int          WORD_MFR_SUMMARY     = 12;
	localparam int          WORD_NOT_GOOD        = 11;
	localparam int          WORD_RSVD_HI         = 10;
	localparam int          WORD_OTHER           = 9;
	localparam int          WORD_RSVD_LO         = 8;
	localparam logic [15:0] WORD_RESET           = 16'h0000;
	localparam logic        RSVD_BIT_VAL         = 1'b0;

	// Open-drain pin levels
	localparam logic        PIN_PULL_LEVEL       = 1'b0;

	// Read and write transfer lengths
	typedef enum logic [1:0] {
		LEN_BYTE = 2'b01,
		LEN_WORD = 2'b10
	} xfer_len_type;

endpackage

//--- vout_flag_if.sv
// Carrier between the status top and its flag storage.
// Assumes one clock domain; all signals are single-cycle qualified.
`timescale 1ns/1ns
`default_nettype none

interface vout_flag_if;
	import status_pkg::*;

	logic [VOUT_FLAG_COUNT-1:0] set_req;
	logic [VOUT_FLAG_COUNT-1:0] clr_req;
	logic                       clr_all;
	logic [VOUT_FLAG_COUNT-1:0] flags;

	modport ctrl (output set_req, output clr_req, output clr_all,
		input flags);
	modport store (input set_req, input clr_req, input clr_all,
		output flags);

endinterface // vout_flag_if

`default_nettype wire

//--- vout_flag_store.sv
// Sticky output voltage flags, one bit per supported condition.
// Assumes set and clear requests are already qualified by the caller.
`timescale 1ns/1ns
`default_nettype none

module vout_flag_store
	import status_pkg::*;
(
	input  wire logic     i_core_clk,
	input  wire logic     i_sys_rst,
	vout_flag_if.store    flag_bus
);

	logic [VOUT_FLAG_COUNT-1:0] flag_r;
	logic [VOUT_FLAG_COUNT-1:0] flag_nxt;

	genvar g;
	generate
		for (g = 0; g < VOUT_FLAG_COUNT; g++) begin : g_flag
			// A new detection outweighs any clear in the same cycle
			assign flag_nxt[g] = flag_bus.set_req[g] |
				(flag_r[g] & ~flag_bus.clr_req[g] & ~flag_bus.clr_all);
		end
	endgenerate

	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			flag_r <= VOUT_FLAGS_RESET;
		end else begin
			flag_r <= flag_nxt;
		end
	end

	assign flag_bus.flags = flag_r;

endmodule // vout_flag_store

`default_nettype wire

//--- power_ok_driver.sv
// Live output-not-good flag and the open-drain power-ok pin driver.
// Assumes the window comparator input is already synchronous.
`timescale 1ns/1ns
`default_nettype none

module power_ok_driver
	import status_pkg::*;
(
	input  wire logic i_core_clk,
	input  wire logic i_sys_rst,
	input  wire logic i_vout_outside_window,
	input  wire logic i_secondary,
	output var  logic o_not_good,
	output var  logic o_power_ok_pin_o,
	output var  logic o_power_ok_pin_oe
);

	logic not_good_r;
	logic not_good_nxt;

	// Follows the output, never latched; a stack secondary stays quiet
	assign not_good_nxt = i_vout_outside_window & ~i_secondary;

	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			not_good_r <= WORD_RESET[WORD_NOT_GOOD];
		end else begin
			not_good_r <= not_good_nxt;
		end
	end

	assign o_not_good        = not_good_r;
	assign o_power_ok_pin_o  = PIN_PULL_LEVEL;
	assign o_power_ok_pin_oe = not_good_r;

endmodule // power_ok_driver

`default_nettype wire

//--- output_status_top_asserts.sv
// Concurrent checks on the ports of the output status top.
// Assumes one core clock and a synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none
module output_status_checker
	import status_pkg::*;
(
	input wire logic                     i_core_clk,
	input wire logic                     i_sys_rst,
	input wire logic                     i_wr_en,
	input wire logic [7:0]               i_wr_code,
	input wire status_pkg::xfer_len_type i_wr_len,
	input wire logic                     i_rd_en,
	input wire logic [7:0]               i_rd_code,
	input wire status_pkg::xfer_len_type i_rd_len,
	input wire logic                     o_rd_valid,
	input wire logic                     o_rd_hit,
	input wire logic [15:0]              o_rd_data,
	input wire logic                     o_cml_data_fault,
	input wire logic                     i_vout_outside_window,
	input wire logic                     i_secondary,
	input wire logic                     i_ovf_det,
	input wire logic                     i_ovw_det,
	input wire logic                     i_uvw_det,
	input wire logic                     i_uvf_det,
	input wire logic                     i_limit_req_det,
	input wire logic [4:0]               i_flag_disable,
	input wire logic [4:0]               o_fault_response,
	input wire logic                     o_output_not_good_flag,
	input wire logic                     o_power_ok_pin_o,
	input wire logic                     o_power_ok_pin_oe
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_sys_rst);
	// ------------
	// Properties
	// ------------
	sequence vout_rd;
		i_rd_en && i_rd_code == CMD_VOUT_STATUS && i_rd_len == LEN_BYTE;
	endsequence
	sequence word_rd;
		i_rd_en && i_rd_code == CMD_STATUS_WORD && i_rd_len == LEN_WORD;
	endsequence
	sequence bad_xfer;
		(i_wr_en && (i_wr_code == CMD_STATUS_WORD ||
		(i_wr_code == CMD_VOUT_STATUS && i_wr_len == LEN_WORD))) ||
		(i_rd_en && ((i_rd_code == CMD_VOUT_STATUS && i_rd_len == LEN_WORD)
		|| (i_rd_code == CMD_STATUS_WORD && i_rd_len == LEN_BYTE)));
	endsequence
	not_good_live_a: assert property (
		!$past(i_sys_rst) |-> o_output_not_good_flag ==
		($past(i_vout_outside_window) && !$past(i_secondary)))
		else $error("not-good flag does not follow the window");
	secondary_quiet_a: assert property (
		i_secondary |=> !o_output_not_good_flag)
		else $error("not-good flag set on a secondary");
	pin_drive_a: assert property (
		o_power_ok_pin_oe == o_output_not_good_flag &&
		o_power_ok_pin_o == PIN_PULL_LEVEL)
		else $error("power-ok pin disagrees with not-good flag");
	read_answer_a: assert property (
		!$past(i_sys_rst) |-> o_rd_valid == $past(i_rd_en))
		else $error("read answer not one cycle after request");
	vout_zero_a: assert property (
		vout_rd |=> o_rd_valid && o_rd_hit && o_rd_data[15:8] == 8'h00 &&
		o_rd_data[2:0] == VOUT_UNSUPPORTED_VAL)
		else $error("voltage status read has bad fixed bits");
	word_fixed_a: assert property (
		word_rd |=> o_rd_hit && o_rd_data[10] == RSVD_BIT_VAL &&
		o_rd_data[8] == RSVD_BIT_VAL &&
		o_rd_data[11] == $past(o_output_not_good_flag))
		else $error("status word read has bad bits");
	// A refused write may share its cycle with a good read, so the hit
	// check is tied to the read side only
	bad_xfer_a: assert property (
		bad_xfer |=> o_cml_data_fault)
		else $error("invalid transfer not flagged");
	bad_read_a: assert property (
		i_rd_en &&
		!(i_rd_code == CMD_VOUT_STATUS && i_rd_len == LEN_BYTE) &&
		!(i_rd_code == CMD_STATUS_WORD && i_rd_len == LEN_WORD)
		|=> !o_rd_hit)
		else $error("invalid read reported as hit");
	miss_read_a: assert property (
		i_rd_en && i_rd_code != CMD_STATUS_WORD &&
		i_rd_code != CMD_VOUT_STATUS |=> !o_rd_hit && o_rd_data == 16'h0000)
		else $error("unknown code read answered");
	fault_gate_a: assert property (
		!$past(i_sys_rst) |-> o_fault_response == ({$past(i_ovf_det),
		$past(i_ovw_det), $past(i_uvw_det), $past(i_uvf_det),
		$past(i_limit_req_det)} & ~$past(i_flag_disable)))
		else $error("fault response ignores disable bits");
endmodule // output_status_checker

bind output_status_top output_status_checker output_status_checker_i (
	.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_wr_en(i_wr_en),
	.i_wr_code(i_wr_code), .i_wr_len(i_wr_len), .i_rd_en(i_rd_en),
	.i_rd_code(i_rd_code), .i_rd_len(i_rd_len), .o_rd_valid(o_rd_valid),
	.o_rd_hit(o_rd_hit), .o_rd_data(o_rd_data),
	.o_cml_data_fault(o_cml_data_fault),
	.i_vout_outside_window(i_vout_outside_window),
	.i_secondary(i_secondary), .i_ovf_det(i_ovf_det),
	.i_ovw_det(i_ovw_det), .i_uvw_det(i_uvw_det), .i_uvf_det(i_uvf_det),
	.i_limit_req_det(i_limit_req_det), .i_flag_disable(i_flag_disable),
	.o_fault_response(o_fault_response),
	.o_output_not_good_flag(o_output_not_good_flag),
	.o_power_ok_pin_o(o_power_ok_pin_o),
	.o_power_ok_pin_oe(o_power_ok_pin_oe));
`default_nettype wire

//--- pmbus_host_model.sv
// Management-bus host issuing decoded command transfers.
// Assumes tasks are entered just after a falling clock edge.
`timescale 1ns/1ns
`default_nettype none
module pmbus_host_model
	import status_pkg::*;
(
	input  wire logic                     i_core_clk,
	input  wire logic                     i_rd_valid,
	input  wire logic                     i_rd_hit,
	input  wire logic [15:0]              i_rd_data,
	output var  logic                     o_wr_en,
	output var  logic [7:0]               o_wr_code,
	output var  status_pkg::xfer_len_type o_wr_len,
	output var  logic [15:0]              o_wr_data,
	output var  logic                     o_rd_en,
	output var  logic [7:0]               o_rd_code,
	output var  status_pkg::xfer_len_type o_rd_len
);
	initial begin
		{o_wr_en, o_rd_en, o_wr_code, o_rd_code, o_wr_data} = '0;
		o_wr_len = LEN_BYTE;
		o_rd_len = LEN_BYTE;
	end
	// ------------
	// Transfers
	// ------------
	// Released fields show the inverse, so stale codes never look valid; an inverted length is the other valid length
	task automatic wr(input logic [7:0] c, input xfer_len_type l,
		input logic [15:0] v);
		// One idle edge first, so back-to-back calls never re-raise a strobe
		@(negedge i_core_clk);
		o_wr_en = 1'b1;
		o_wr_code = c;
		o_wr_len = l;
		o_wr_data = v;
		@(negedge i_core_clk);
		o_wr_en = 1'b0;
		o_wr_code = ~c;
		o_wr_len = xfer_len_type'(~l);
		o_wr_data = ~v;
	endtask
	task automatic rd(input logic [7:0] c, input xfer_len_type l,
		output logic [15:0] v, output logic [1:0] vh);
		@(negedge i_core_clk);
		o_rd_en = 1'b1;
		o_rd_code = c;
		o_rd_len = l;
		@(negedge i_core_clk);
		vh = {i_rd_valid, i_rd_hit};
		v = i_rd_data;
		o_rd_en = 1'b0;
		o_rd_code = ~c;
		o_rd_len = xfer_len_type'(~l);
	endtask
endmodule // pmbus_host_model
`default_nettype wire

//--- output_status_top_test.sv
// Self-checking bench for the output status top and its host model.
// Assumes the status package and all design files are compiled first.
`timescale 1ns/1ns
`default_nettype none
module output_status_top_test;
	import status_pkg::*;
	logic         clk, rst, wr_en, rd_en, cf, ton, outside, ssd, sec, fta;
	logic [7:0]   wr_code, rd_code, sbyte;
	xfer_len_type wr_len, rd_len;
	logic [15:0]  wr_data, rd_data, amask, d, w;
	logic         rd_valid, rd_hit, cml, ng, pg_o, pg_oe, al_o, al_oe;
	logic [4:0]   det, dis, set, clr;
	logic [2:0]   sums;
	logic [1:0]   vh;
	logic [31:0]  r;
	int           num_errors, n_checks, flags, k;
	output_status_top output_status_top_i (
		.i_core_clk(clk), .i_sys_rst(rst), .i_wr_en(wr_en),
		.i_wr_code(wr_code), .i_wr_len(wr_len), .i_wr_data(wr_data),
		.i_rd_en(rd_en), .i_rd_code(rd_code), .i_rd_len(rd_len),
		.o_rd_valid(rd_valid), .o_rd_hit(rd_hit), .o_rd_data(rd_data),
		.o_cml_data_fault(cml), .i_vout_outside_window(outside),
		.i_ovf_det(det[4]), .i_ovw_det(det[3]), .i_uvw_det(det[2]),
		.i_uvf_det(det[1]), .i_limit_req_det(det[0]),
		.i_soft_start_done(ssd), .i_flag_disable(dis),
		.i_clear_faults(cf), .i_output_turn_on(ton), .i_secondary(sec),
		.i_first_to_alert_flag(fta), .i_iout_summary(sums[2]),
		.i_input_summary(sums[1]), .i_mfr_summary(sums[0]),
		.i_status_byte(sbyte), .i_alert_mask(amask),
		.o_fault_response(), .o_output_not_good_flag(ng),
		.o_power_ok_pin_o(pg_o), .o_power_ok_pin_oe(pg_oe),
		.o_bus_alert_o(al_o), .o_bus_alert_oe(al_oe));
	pmbus_host_model pmbus_host_model_i (
		.i_core_clk(clk), .i_rd_valid(rd_valid), .i_rd_hit(rd_hit),
		.i_rd_data(rd_data), .o_wr_en(wr_en), .o_wr_code(wr_code),
		.o_wr_len(wr_len), .o_wr_data(wr_data), .o_rd_en(rd_en),
		.o_rd_code(rd_code), .o_rd_len(rd_len));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic test_done;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		test_done();
	end
	// ------------
	// Scenarios
	// ------------
	initial begin
		{det, dis, cf, ton, outside, ssd, sec, fta, sums, sbyte} = '0;
		amask = 16'h0000;
		r = 32'h9a1b;
		flags = 0;
		rst = 1'b1;
		repeat (20) @(negedge clk);
		rst = 1'b0;
		for (int i = 0; i < 80; i++) begin
			repeat (7) r = lfsr(r);
			det = r[4:0];
			dis = r[9:5] & r[14:10];
			ssd = r[15];
			cf = r[18:16] == 3'h0;
			ton = r[18:16] == 3'h1;
			{outside, sec, fta, sums, sbyte} = r[31:18];
			amask = r[31:16] ^ r[15:0];
			k = r[26:25];
			set[4] = det[4] & ~dis[4];
			set[1] = det[1] & ~dis[1];
			set[3] = (det[3] | (set[4] & ssd)) & ~dis[3];
			set[2] = (det[2] | set[1]) & ~dis[2];
			set[0] = det[0] & ~dis[0];
			clr = (cf || ton) ? 5'h1f : (k < 2 ? r[23:19] : 5'h00);
			flags = (flags & ~clr) | set;
			// Word writes and 79h writes are refused and leave flags alone
			pmbus_host_model_i.wr(k == 2 ? CMD_STATUS_WORD : CMD_VOUT_STATUS,
				xfer_len_type'(k > 1 ? LEN_WORD : LEN_BYTE), r[31:16]);
			{det, cf, ton} = '0;
			check({15'h0, cml}, {15'h0, k > 1});
			pmbus_host_model_i.rd(CMD_VOUT_STATUS, LEN_BYTE, d, vh);
			check({vh, 6'h00, d[7:0]}, {8'hc0, flags[4:0], 3'h0});
			w = {|flags[4:0], sums, outside & ~sec, 1'b0, fta, 1'b0, sbyte};
			pmbus_host_model_i.rd(CMD_STATUS_WORD, LEN_WORD, d, vh);
			check(d, w);
			check({14'h0, al_o, al_oe}, {15'h0, |(w & ~amask)});
			check({14'h0, pg_o, pg_oe}, {15'h0, w[11]});
		end
		for (int j = 0; j < 3; j++) begin
			pmbus_host_model_i.rd(j == 0 ? 8'h7b : (j == 1 ? CMD_VOUT_STATUS
				: CMD_STATUS_WORD), xfer_len_type'(j == 1 ? LEN_WORD
				: LEN_BYTE), d, vh);
			check({14'h0, vh}, 16'h0002);
			check({15'h0, cml}, {15'h0, j != 0});
			if (j == 0)
				check(d, 16'h0000);
		end
		det = 5'h1f;
		dis = 5'h00;
		@(negedge clk);
		det = 5'h00;
		pmbus_host_model_i.rd(CMD_VOUT_STATUS, LEN_BYTE, d, vh);
		check({vh, 6'h00, d[7:0]}, 16'hc0f8);
		rst = 1'b1;
		repeat (20) @(negedge clk);
		rst = 1'b0;
		pmbus_host_model_i.rd(CMD_VOUT_STATUS, LEN_BYTE, d, vh);
		check(d, 16'h0000);
		test_done();
	end
endmodule // output_status_top_test
`default_nettype wire
